/* File: chg_pkg.sv */
package chg_pkg;

    localparam int CLK_HZ = 25_000_000;

    // Register offsets.
    localparam logic [7:0] ADDR_CHARGE_CONTROL_TIMERS = 8'h05;
    localparam logic [7:0] ADDR_INPUT_LIMITS_BOOST = 8'h06;
    localparam logic [7:0] ADDR_MISC_SWITCH_TRACKING = 8'h07;
    localparam logic [7:0] ADDR_SYSTEM_STATUS = 8'h08;
    localparam logic [7:0] ADDR_FAULT_STATUS = 8'h09;
    localparam logic [7:0] ADDR_RESET_CONTROL = 8'h0B;

    // Power-on values and the bits that a watchdog expiry restores.
    localparam logic [7:0] CCT_POR = 8'h9F;
    localparam logic [7:0] ILB_POR = 8'h66;
    localparam logic [7:0] MSC_POR = 8'h4C;
    localparam logic [7:0] CCT_WD_MASK = 8'hFF;
    localparam logic [7:0] ILB_WD_MASK = 8'h00;
    localparam logic [7:0] MSC_WD_MASK = 8'hD4;

    // Field positions in charge_control_timers.
    localparam int CCT_TERM_EN = 7;
    localparam int CCT_WD_HI = 5;
    localparam int CCT_WD_LO = 4;
    localparam int CCT_TIMER_EN = 3;
    localparam int CCT_TIMER_LEN = 2;
    localparam int CCT_THERM_THR = 1;
    localparam int CCT_COLD_ISET = 0;
    // Field positions in input_limits_boost_voltage.
    localparam int ILB_OVP_HI = 7;
    localparam int ILB_OVP_LO = 6;
    localparam int ILB_BOOST_HI = 5;
    localparam int ILB_BOOST_LO = 4;
    localparam int ILB_VLIM_HI = 3;
    localparam int ILB_VLIM_LO = 0;
    // Field positions in misc_switch_tracking_control.
    localparam int MSC_DETECT = 7;
    localparam int MSC_SLOWDOWN = 6;
    localparam int MSC_SW_DISABLE = 5;
    localparam int MSC_HOT_VSEL = 4;
    localparam int MSC_SW_DELAY = 3;
    localparam int MSC_SW_RST_EN = 2;
    localparam int MSC_TRACK_HI = 1;
    localparam int MSC_TRACK_LO = 0;
    // Other bit positions.
    localparam int RESET_BIT = 7;
    localparam int FAULT_WD_BIT = 7;

    // Serial port framing.
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // Times in seconds.
    localparam logic [7:0] WD_SHORT_S = 8'h28;  // 40 s
    localparam logic [7:0] WD_MID_S = 8'h50;    // 80 s
    localparam logic [7:0] WD_LONG_S = 8'hA0;   // 160 s
    localparam logic [7:0] SW_DELAY_S = 8'h0A;  // 10 s

    // Voltages in millivolts.
    localparam logic [15:0] VLIM_BASE_MV = 16'h0F3C;  // 3900 mV
    localparam logic [15:0] VLIM_STEP_MV = 16'h0064;  // 100 mV
    localparam logic [15:0] TRACK_LOW_MV = 16'h00C8;  // 200 mV
    localparam logic [15:0] TRACK_MID_MV = 16'h00FA;  // 250 mV
    localparam logic [15:0] TRACK_HIGH_MV = 16'h012C; // 300 mV

    typedef struct packed {
        logic [2:0] input_source_status;
        logic [1:0] charge_phase_status;
        logic power_good_status;
        logic thermal_regulation_status;
        logic min_system_regulation_status;
    } status_t;

    typedef struct packed {
        logic input_voltage_regulation;
        logic input_current_regulation;
        logic cool_zone;
        logic hot_zone;
    } regulation_t;

    typedef struct packed {
        logic term_enable;
        logic safety_timer_enable;
        logic fast_charge_timer_length;
        logic thermal_regulation_threshold;
        logic cold_zone_current_select;
        logic [1:0] input_overvoltage_threshold;
        logic [1:0] boost_output_voltage;
        logic input_detect_request;
        logic battery_switch_reset_enable;
        logic charge_voltage_cap;
    } control_t;

    // Sync vector is {scl, sda, regulation, status}; the bus lines idle high.
    localparam int SYNC_W = 14;
    localparam logic [13:0] SYNC_RST = 14'h3000;

    function automatic logic [7:0] wd_period(input logic [1:0] code);
        case (code)
            2'b01: wd_period = WD_SHORT_S;
            2'b10: wd_period = WD_MID_S;
            2'b11: wd_period = WD_LONG_S;
            default: wd_period = 8'h00;
        endcase
    endfunction : wd_period

    function automatic logic [15:0] track_offset(input logic [1:0] code);
        case (code)
            2'b01: track_offset = TRACK_LOW_MV;
            2'b10: track_offset = TRACK_MID_MV;
            2'b11: track_offset = TRACK_HIGH_MV;
            default: track_offset = 16'h0000;
        endcase
    endfunction : track_offset

endpackage : chg_pkg

/* File: charger_config_status_regs.sv */
`timescale 1ns/1ps
module charger_config_status_regs #(
    parameter logic [6:0] DEVICE_ADDR = 7'h6B,
    parameter int SEC_CYCLES = chg_pkg::CLK_HZ
) (
    // Clock, reset and enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // Serial register port
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Analog status, asynchronous
    input wire chg_pkg::status_t status_in,
    input wire chg_pkg::regulation_t regulation_in,
    // Same-clock measurement and handshake
    input wire logic [15:0] battery_mv,
    input wire logic detect_done,
    // Controls to the charger
    output chg_pkg::control_t control,
    output logic [15:0] input_voltage_limit_mv,
    output logic battery_switch_off,
    output logic safety_timer_tick,
    output logic safety_timer_restart
);

    typedef enum logic [3:0] {
        I_IDLE, I_ADDR, I_ADDR_ACK, I_PTR, I_PTR_ACK, I_WR, I_WR_ACK, I_RD, I_RD_ACK
    } i2c_state_t;

    logic [chg_pkg::SYNC_W-1:0] s1, s2, s3, filt;
    logic scl_f, sda_f, scl_q, sda_q;
    logic start_cond, stop_cond, scl_rise, scl_fall;
    chg_pkg::status_t stat_f;
    chg_pkg::regulation_t reg_f;

    i2c_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift, tx, ptr, read_byte;
    logic rw, nack;
    logic wr_stb, rd_stb;
    logic [7:0] wr_addr, wr_data, rd_addr;

    logic [7:0] charge_control_timers;
    logic [7:0] input_limits_boost_voltage;
    logic [7:0] misc_switch_tracking_control;
    logic wd_fault, wd_expire, reg_reset_req;
    logic [7:0] wd_sec, wd_limit, sw_sec;
    logic [31:0] pre_cnt;
    logic sec_tick, half, slow;
    logic [15:0] vlim_reg, vlim_track;

    // Pin and analog inputs: three stages, a change taken once stages two and three agree.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= chg_pkg::SYNC_RST;
            s2 <= chg_pkg::SYNC_RST;
            s3 <= chg_pkg::SYNC_RST;
            filt <= chg_pkg::SYNC_RST;
        end else if (ce) begin
            s1 <= {scl, sda_in, regulation_in, status_in};
            s2 <= s1;
            s3 <= s2;
            filt <= (s2 & s3) | (filt & (s2 ^ s3));
        end
    end

    assign scl_f = filt[13];
    assign sda_f = filt[12];
    assign reg_f = filt[11:8];
    assign stat_f = filt[7:0];

    assign start_cond = scl_f && scl_q && sda_q && !sda_f;
    assign stop_cond = scl_f && scl_q && !sda_q && sda_f;
    assign scl_rise = scl_f && !scl_q;
    assign scl_fall = !scl_f && scl_q;

    // Register read mux; the reset control reads back 0 once its restore is done.
    always_comb begin
        case (ptr)
            chg_pkg::ADDR_CHARGE_CONTROL_TIMERS: read_byte = charge_control_timers;
            chg_pkg::ADDR_INPUT_LIMITS_BOOST: read_byte = input_limits_boost_voltage;
            chg_pkg::ADDR_MISC_SWITCH_TRACKING: read_byte = misc_switch_tracking_control;
            chg_pkg::ADDR_SYSTEM_STATUS: read_byte = stat_f;
            chg_pkg::ADDR_FAULT_STATUS: read_byte = {wd_fault, 7'h00};
            chg_pkg::ADDR_RESET_CONTROL: read_byte = 8'h00;
            default: read_byte = 8'h00;
        endcase
    end

    // Serial slave: address, pointer, then data bytes with pointer auto-increment.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= I_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            tx <= 8'h00;
            ptr <= 8'h00;
            rw <= 1'b0;
            nack <= 1'b0;
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
            rd_addr <= 8'h00;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
        end else if (ce) begin
            scl_q <= scl_f;
            sda_q <= sda_f;
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
            if (start_cond) begin
                state <= I_ADDR;
                bit_cnt <= 4'h0;
                sda_oe_n <= 1'b1;
            end else if (stop_cond) begin
                state <= I_IDLE;
                sda_oe_n <= 1'b1;
            end else if (scl_rise) begin
                if (state inside {I_ADDR, I_PTR, I_WR}) begin
                    shift <= {shift[6:0], sda_f};
                    bit_cnt <= bit_cnt + 4'h1;
                end
                if (state == I_RD_ACK) begin
                    nack <= sda_f;
                end
            end else if (scl_fall) begin
                unique case (state)
                    I_IDLE: begin
                    end
                    I_ADDR: begin
                        if (bit_cnt == chg_pkg::BYTE_BITS) begin
                            if (shift[7:1] == DEVICE_ADDR) begin
                                state <= I_ADDR_ACK;
                                sda_oe_n <= 1'b0;
                                rw <= shift[0];
                            end else begin
                                state <= I_IDLE;
                            end
                        end
                    end
                    I_ADDR_ACK: begin
                        if (rw) begin
                            state <= I_RD;
                            sda_oe_n <= read_byte[7];
                            tx <= {read_byte[6:0], 1'b0};
                            bit_cnt <= 4'h1;
                            rd_stb <= 1'b1;
                            rd_addr <= ptr;
                            ptr <= ptr + 8'h01;
                        end else begin
                            state <= I_PTR;
                            sda_oe_n <= 1'b1;
                            bit_cnt <= 4'h0;
                        end
                    end
                    I_PTR: begin
                        if (bit_cnt == chg_pkg::BYTE_BITS) begin
                            ptr <= shift;
                            state <= I_PTR_ACK;
                            sda_oe_n <= 1'b0;
                        end
                    end
                    I_PTR_ACK: begin
                        state <= I_WR;
                        sda_oe_n <= 1'b1;
                        bit_cnt <= 4'h0;
                    end
                    I_WR: begin
                        if (bit_cnt == chg_pkg::BYTE_BITS) begin
                            wr_stb <= 1'b1;
                            wr_addr <= ptr;
                            wr_data <= shift;
                            state <= I_WR_ACK;
                            sda_oe_n <= 1'b0;
                        end
                    end
                    I_WR_ACK: begin
                        state <= I_WR;
                        sda_oe_n <= 1'b1;
                        ptr <= ptr + 8'h01;
                        bit_cnt <= 4'h0;
                    end
                    I_RD: begin
                        if (bit_cnt == chg_pkg::BYTE_BITS) begin
                            state <= I_RD_ACK;
                            sda_oe_n <= 1'b1;
                        end else begin
                            sda_oe_n <= tx[7];
                            tx <= {tx[6:0], 1'b0};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                    I_RD_ACK: begin
                        if (nack) begin
                            state <= I_IDLE;
                        end else begin
                            state <= I_RD;
                            sda_oe_n <= read_byte[7];
                            tx <= {read_byte[6:0], 1'b0};
                            bit_cnt <= 4'h1;
                            rd_stb <= 1'b1;
                            rd_addr <= ptr;
                            ptr <= ptr + 8'h01;
                        end
                    end
                endcase
            end
        end
    end

    assign reg_reset_req = wr_stb && (wr_addr == chg_pkg::ADDR_RESET_CONTROL)
                           && wr_data[chg_pkg::RESET_BIT];

    // Register file. Later assignments win, so a host write beats the detect clear.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            charge_control_timers <= chg_pkg::CCT_POR;
            input_limits_boost_voltage <= chg_pkg::ILB_POR;
            misc_switch_tracking_control <= chg_pkg::MSC_POR;
        end else if (ce) begin
            if (reg_reset_req) begin
                charge_control_timers <= chg_pkg::CCT_POR;
                input_limits_boost_voltage <= chg_pkg::ILB_POR;
                misc_switch_tracking_control <= chg_pkg::MSC_POR;
            end else begin
                if (wd_expire) begin
                    charge_control_timers <= (charge_control_timers & ~chg_pkg::CCT_WD_MASK)
                        | (chg_pkg::CCT_POR & chg_pkg::CCT_WD_MASK);
                    input_limits_boost_voltage <=
                        (input_limits_boost_voltage & ~chg_pkg::ILB_WD_MASK)
                        | (chg_pkg::ILB_POR & chg_pkg::ILB_WD_MASK);
                    misc_switch_tracking_control <=
                        (misc_switch_tracking_control & ~chg_pkg::MSC_WD_MASK)
                        | (chg_pkg::MSC_POR & chg_pkg::MSC_WD_MASK);
                end else if (detect_done) begin
                    misc_switch_tracking_control[chg_pkg::MSC_DETECT] <= 1'b0;
                end
                if (wr_stb) begin
                    case (wr_addr)
                        chg_pkg::ADDR_CHARGE_CONTROL_TIMERS: charge_control_timers <= wr_data;
                        chg_pkg::ADDR_INPUT_LIMITS_BOOST: input_limits_boost_voltage <= wr_data;
                        chg_pkg::ADDR_MISC_SWITCH_TRACKING: misc_switch_tracking_control <= wr_data;
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    // One-second prescaler.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt <= 32'h0000_0000;
            sec_tick <= 1'b0;
        end else if (ce) begin
            sec_tick <= (pre_cnt == 32'(SEC_CYCLES - 1));
            pre_cnt <= (pre_cnt == 32'(SEC_CYCLES - 1)) ? 32'h0000_0000 : pre_cnt + 32'h1;
        end
    end

    assign wd_limit = chg_pkg::wd_period(
        charge_control_timers[chg_pkg::CCT_WD_HI:chg_pkg::CCT_WD_LO]);

    // Host watchdog: any register write services it.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wd_sec <= 8'h00;
            wd_expire <= 1'b0;
        end else if (ce) begin
            wd_expire <= 1'b0;
            if (wr_stb || wd_limit == 8'h00) begin
                wd_sec <= 8'h00;
            end else if (sec_tick) begin
                if (wd_sec + 8'h01 == wd_limit) begin
                    wd_expire <= 1'b1;
                    wd_sec <= 8'h00;
                end else begin
                    wd_sec <= wd_sec + 8'h01;
                end
            end
        end
    end

    // Watchdog fault: set by expiry, cleared by reading it; the set wins.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wd_fault <= 1'b0;
        end else if (ce) begin
            if (wd_expire) begin
                wd_fault <= 1'b1;
            end else if (rd_stb && rd_addr == chg_pkg::ADDR_FAULT_STATUS) begin
                wd_fault <= 1'b0;
            end
        end
    end

    assign slow = misc_switch_tracking_control[chg_pkg::MSC_SLOWDOWN]
                  && (reg_f.input_voltage_regulation || reg_f.input_current_regulation
                      || reg_f.cool_zone || stat_f.thermal_regulation_status);

    // Safety timer time base: one tick a second, every second second when slowed.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            half <= 1'b0;
            safety_timer_tick <= 1'b0;
            safety_timer_restart <= 1'b0;
        end else if (ce) begin
            safety_timer_tick <= 1'b0;
            safety_timer_restart <= reg_reset_req;
            if (reg_reset_req) begin
                half <= 1'b0;
            end else if (sec_tick && charge_control_timers[chg_pkg::CCT_TIMER_EN]) begin
                if (slow) begin
                    half <= !half;
                    safety_timer_tick <= half;
                end else begin
                    safety_timer_tick <= 1'b1;
                end
            end
        end
    end

    // Battery switch turn-off, at once or after the delay.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sw_sec <= 8'h00;
            battery_switch_off <= 1'b0;
        end else if (ce) begin
            if (!misc_switch_tracking_control[chg_pkg::MSC_SW_DISABLE]) begin
                sw_sec <= 8'h00;
                battery_switch_off <= 1'b0;
            end else if (!misc_switch_tracking_control[chg_pkg::MSC_SW_DELAY]) begin
                battery_switch_off <= 1'b1;
            end else if (sec_tick && !battery_switch_off) begin
                sw_sec <= sw_sec + 8'h01;
                battery_switch_off <= (sw_sec + 8'h01 == chg_pkg::SW_DELAY_S);
            end
        end
    end

    assign vlim_reg = 16'(chg_pkg::VLIM_BASE_MV + 16'(input_limits_boost_voltage[
        chg_pkg::ILB_VLIM_HI:chg_pkg::ILB_VLIM_LO] * chg_pkg::VLIM_STEP_MV));
    assign vlim_track = 16'(battery_mv + chg_pkg::track_offset(misc_switch_tracking_control[
        chg_pkg::MSC_TRACK_HI:chg_pkg::MSC_TRACK_LO]));

    // Registered controls to the charger.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            control <= '0;
            input_voltage_limit_mv <= 16'h0000;
        end else if (ce) begin
            control.term_enable <= charge_control_timers[chg_pkg::CCT_TERM_EN];
            control.safety_timer_enable <= charge_control_timers[chg_pkg::CCT_TIMER_EN];
            control.fast_charge_timer_length <=
                charge_control_timers[chg_pkg::CCT_TIMER_LEN];
            control.thermal_regulation_threshold <= charge_control_timers[chg_pkg::CCT_THERM_THR];
            control.cold_zone_current_select <= charge_control_timers[chg_pkg::CCT_COLD_ISET];
            control.input_overvoltage_threshold <=
                input_limits_boost_voltage[chg_pkg::ILB_OVP_HI:chg_pkg::ILB_OVP_LO];
            control.boost_output_voltage <=
                input_limits_boost_voltage[chg_pkg::ILB_BOOST_HI:chg_pkg::ILB_BOOST_LO];
            control.input_detect_request <= misc_switch_tracking_control[chg_pkg::MSC_DETECT]
                && stat_f.power_good_status;
            control.battery_switch_reset_enable <=
                misc_switch_tracking_control[chg_pkg::MSC_SW_RST_EN];
            control.charge_voltage_cap <= reg_f.hot_zone
                && !misc_switch_tracking_control[chg_pkg::MSC_HOT_VSEL];
            if (misc_switch_tracking_control[chg_pkg::MSC_TRACK_HI:chg_pkg::MSC_TRACK_LO] != 2'b00
                && vlim_track > vlim_reg) begin
                input_voltage_limit_mv <= vlim_track;
            end else begin
                input_voltage_limit_mv <= vlim_reg;
            end
        end
    end

endmodule : charger_config_status_regs

/* File: charger_regs_chk_sva.sv */
`timescale 1ns/1ps
module charger_regs_chk (
    input wire logic mclk, rst_n, ce, scl, sda_in, sda_out, sda_oe_n, detect_done,
    input wire chg_pkg::status_t status_in,
    input wire chg_pkg::regulation_t regulation_in,
    input wire logic [15:0] battery_mv, input_voltage_limit_mv,
    input wire chg_pkg::control_t control,
    input wire logic battery_switch_off, safety_timer_tick, safety_timer_restart
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence defaults_seen;
        control.term_enable && control.safety_timer_enable && control.fast_charge_timer_length &&
        control.input_overvoltage_threshold == 2'h1 && input_voltage_limit_mv == 16'h1194;
    endsequence
    por_load_a: assert property ($rose(rst_n) && ce |=> defaults_seen)
        else $error("defaults missing after reset");
    restore_all_a: assert property (safety_timer_restart |=> defaults_seen)
        else $error("defaults missing at restart");
    restart_pulse_a: assert property (safety_timer_restart |=> !safety_timer_restart)
        else $error("restart too long");
    tick_enable_a: assert property (safety_timer_tick |-> control.safety_timer_enable ||
        $past(control.safety_timer_enable)) else $error("tick while disabled");
    tick_gap_a: assert property (safety_timer_tick |=> !safety_timer_tick [*8])
        else $error("ticks too close");
    limit_range_a: assert property ($past(rst_n) |-> input_voltage_limit_mv >= 16'h0F3C &&
        (input_voltage_limit_mv <= 16'h1518 ||
        input_voltage_limit_mv <= $past(battery_mv, 2) + 16'h012C ||
        input_voltage_limit_mv <= $past(battery_mv) + 16'h012C)) else $error("limit out of range");
    ack_low_a: assert property ($fell(sda_oe_n) |-> !scl) else $error("data pulled, clock high");
    pull_only_a: assert property (!sda_out) else $error("data line driven high");
endmodule : charger_regs_chk
bind charger_config_status_regs charger_regs_chk u_charger_regs_chk (.mclk(mclk), .rst_n(rst_n),
    .ce(ce), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .detect_done(detect_done), .status_in(status_in), .regulation_in(regulation_in),
    .battery_mv(battery_mv), .input_voltage_limit_mv(input_voltage_limit_mv), .control(control),
    .battery_switch_off(battery_switch_off), .safety_timer_tick(safety_timer_tick),
    .safety_timer_restart(safety_timer_restart));

/* File: i2c_host_model.sv */
`timescale 1ns/1ps
module i2c_host_model (
    input wire logic mclk,
    input wire logic sda_line,
    output logic scl = 1'b1,
    output logic sda_drv = 1'b1
);
    localparam logic [6:0] DEV = 7'h6B;
    // Only one line moves per 8-cycle phase, so the filter never sees a false start or stop.
    task automatic step(input logic c, input logic v);
        scl = c; sda_drv = v; repeat (8) @(negedge mclk);
    endtask : step
    task automatic xfer(input logic [8:0] tx, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            step(1'b0, tx[i]); step(1'b1, tx[i]); r[i] = sda_line; step(1'b0, tx[i]);
        end
    endtask : xfer
    task automatic start();
        step(1'b0, 1'b1); step(1'b1, 1'b1); step(1'b1, 1'b0); step(1'b0, 1'b0);
    endtask : start
    // Every finished write also services the watchdog.
    task automatic frame(input logic [7:0] a, input logic rnw, input logic [7:0] d,
        output logic [7:0] q, output logic ok);
        logic [8:0] r0, r1, r2, r3;
        start(); xfer({DEV, 2'b01}, r0); xfer({a, 1'b1}, r1);
        if (rnw) begin start(); xfer({DEV, 2'b11}, r2); xfer(9'h1FF, r3); end
        else xfer({d, 1'b1}, r2);
        step(1'b0, 1'b0); step(1'b1, 1'b0); step(1'b1, 1'b1);
        q = r3[8:1]; ok = !(r0[0] | r1[0] | r2[0]);
    endtask : frame
endmodule : i2c_host_model

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    localparam logic R = 1'b1, W = 1'b0;
    logic mclk = 1'b0, rst_n = 1'b0, ce = 1'b1, detect_done = 1'b0, scl, sda_drv, sda_line, ok;
    logic sda_out, sda_oe_n, switch_off, tick, restart;
    logic [15:0] battery_mv = 16'h0E10, vlim;
    logic [7:0] rx, mdl [0:255];
    chg_pkg::status_t status_in = '0;
    chg_pkg::regulation_t regulation_in = '0;
    chg_pkg::control_t control;
    int num_errors = 0, total_checks = 0, cycles = 0, restarts = 0, seed = 32'hC0CFE529, t;
    int ticks = 0;
    assign sda_line = sda_drv & (sda_oe_n | sda_out);
    always #20 mclk = ~mclk;
    charger_config_status_regs #(.SEC_CYCLES(100)) u_charger_config_status_regs (.mclk(mclk),
        .rst_n(rst_n), .ce(ce), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .status_in(status_in), .regulation_in(regulation_in),
        .battery_mv(battery_mv), .detect_done(detect_done), .control(control),
        .input_voltage_limit_mv(vlim), .battery_switch_off(switch_off),
        .safety_timer_tick(tick), .safety_timer_restart(restart));
    i2c_host_model u_i2c_host_model (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        total_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask : check
    task automatic results();
        $display("checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results
    always @(posedge mclk) begin
        cycles++;
        restarts += restart;
        ticks += tick;
        if (cycles == 60000) begin num_errors++; results(); end
    end
    task automatic por();
        mdl[5] = 8'h9F; mdl[6] = 8'h66; mdl[7] = 8'h4C;
    endtask : por
    task automatic acc(input int addr, input logic rnw, input logic [7:0] v);
        u_i2c_host_model.frame(addr[7:0], rnw, v, rx, ok);
        check(ok, 1'b1);
        if (rnw) check(rx, mdl[addr]);
        if (rnw && addr == 9) mdl[9] = 8'h00;
        if (!rnw && addr > 4 && addr < 8) mdl[addr] = v;
        if (!rnw && addr == 11 && v[7]) por();
    endtask : acc
    task automatic ctl();
        int lim, trk;
        lim = 3900 + 100 * mdl[6][3:0];
        trk = (mdl[7][1:0] == 2'h0) ? 0 : battery_mv + 150 + 50 * mdl[7][1:0];
        if (trk > lim) lim = trk;
        check(control, {mdl[5][7], mdl[5][3:0], mdl[6][7:4], mdl[7][7] & status_in.power_good_status,
            mdl[7][2], regulation_in.hot_zone & ~mdl[7][4]});
        check(vlim, 16'(lim));
    endtask : ctl
    initial begin
        for (int i = 0; i < 256; i++) mdl[i] = 8'h00;
        por();
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        repeat (6) @(negedge mclk);
        for (int i = 5; i < 8; i++) acc(i, R, 8'h00);
        ctl();
        $display("done: power-on values");
        acc(5, W, 8'h8F);
        acc(11, R, 8'h00);
        acc(32, R, 8'h00);
        for (int i = 0; i < 4; i++) begin
            status_in = {3'(i == 3 ? 7 : i), 2'(i), 3'($random(seed))};
            mdl[8] = status_in;
            acc(8, R, 8'h00);
        end
        $display("done: status");
        for (int i = 0; i < 6; i++) begin
            battery_mv = 16'h0C80 + 16'($random(seed) & 32'h7FF);
            regulation_in = 4'($random(seed));
            t = $random(seed);
            if (i % 3 == 0) t[5:4] = 2'b00;
            acc(5 + i % 3, W, t[7:0]);
            acc(5 + i % 3, R, 8'h00);
            ctl();
        end
        $display("done: random settings");
        status_in.power_good_status = 1'b1;
        acc(7, W, 8'h80);
        ctl();
        @(negedge mclk) detect_done = 1'b1;
        @(negedge mclk) detect_done = 1'b0;
        mdl[7][7] = 1'b0;
        acc(7, R, 8'h00);
        $display("done: detect");
        t = restarts;
        acc(11, W, 8'h80);
        check(16'(restarts - t), 16'h0001);
        acc(11, R, 8'h00);
        ctl();
        $display("done: register reset");
        acc(7, W, 8'h20);
        check(switch_off, 1'b1);
        acc(7, W, 8'h08);
        check(switch_off, 1'b0);
        acc(7, W, 8'h28);
        t = ticks;
        repeat (800) @(negedge mclk);
        check(switch_off, 1'b0);
        repeat (300) @(negedge mclk);
        check(switch_off, 1'b1);
        check(16'(ticks - t), 16'h000B);
        $display("done: battery switch");
        acc(6, W, 8'h0F);
        acc(7, W, 8'h00);
        acc(5, W, 8'h10);
        t = ticks;
        repeat (3000) @(negedge mclk);
        check(16'(ticks - t), 16'h0000);
        repeat (1200) @(negedge mclk);
        mdl[5] = 8'h9F; mdl[7] = (mdl[7] & 8'h2B) | 8'h44; mdl[9] = 8'h80;
        acc(9, R, 8'h00);
        acc(5, R, 8'h00);
        acc(7, R, 8'h00);
        acc(6, R, 8'h00);
        $display("done: watchdog");
        results();
    end
endmodule : tb_top
